// ---- ewc_pkg.sv ----
// Constants, types and helpers shared by the edge window checker ends.
// Assumes one 10 MHz system clock and a synchronous active-low reset.
package ewc_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned BASE_TICK_NS   = 2000;
  localparam int unsigned BASE_TICK_CYC  = (BASE_TICK_NS / CLK_PERIOD_NS < 1) ? 1 : BASE_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned LIM_W          = 6;
  localparam logic [5:0]  LIM_MIN_RST    = 6'h0e;
  localparam logic [5:0]  LIM_MAX_RST    = 6'h18;
  localparam logic [1:0]  BAND_RST       = 2'h0;
  localparam logic [1:0]  NBIT_RST       = 2'h2;
  localparam logic [4:0]  SLEEP_RST      = 5'h0b;
  localparam logic [7:0]  STARTUP_TICKS  = 8'h20;
  localparam logic [7:0]  HOLD_IN_TICKS  = 8'h08;
  localparam logic [7:0]  HOLD_OUT_TICKS = 8'h0a;
  localparam logic [7:0]  LOW_MAX_TICKS  = 8'h50;
  localparam logic [7:0]  OFF_LOW_TICKS  = 8'h64;
  localparam logic [7:0]  SYNC_TICKS     = 8'h08;
  localparam logic [7:0]  BIT_TICKS      = 8'h10;
  localparam logic [4:0]  CHECKS_PER_STEP = 5'h06;
  // Host register map, word aligned
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_OFF_LOW    = 4'h4;
  localparam logic [3:0]  REG_DOZE       = 4'h8;
  localparam logic [3:0]  REG_STATUS     = 4'hc;
  localparam logic [15:0] OFF_LOW_RST    = 16'h4e20;
  localparam logic [15:0] DOZE_RST       = 16'h0064;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'b000,
    ST_START = 3'b001,
    ST_CHECK = 3'b010,
    ST_RECV  = 3'b011,
    ST_SYNC  = 3'b100,
    ST_BIT   = 3'b101
  } ewc_state_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_OFF  = 2'b01,
    HS_SYNC = 2'b10,
    HS_DOZE = 2'b11
  } ewc_hstate_t;

  // Base ticks per scaled tick for each rate band
  function automatic logic [3:0] ewc_band_div(input logic [1:0] band);
    ewc_band_div = 4'h8 >> band;
  endfunction

  // Edge checks needed for a bit total code
  function automatic logic [4:0] ewc_checks(input logic [1:0] code);
    ewc_checks = 5'(CHECKS_PER_STEP * code);
  endfunction
endpackage

// ---- ewc_link_if.sv ----
// Link between the receiver core and its host: open-drain data, enable.
// Assumes an external pull-up: data reads high unless an end pulls it low.
`timescale 1ns/1ps
interface ewc_link_if;
  logic data_dev_oen;
  logic data_host_oen;
  logic data_line;
  logic enable;

  // Wired-AND of the two open-drain drivers
  assign data_line = data_dev_oen & data_host_oen;

  modport dev  (output data_dev_oen, input data_line, input enable);
  modport host (output data_host_oen, output enable, input data_line);
endinterface

// ---- ewc_dev.sv ----
// Receiver digital core: window check, receive path, return to polling.
// Assumes the demodulated bit and link pins are asynchronous to clk_sys_i.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module ewc_dev #(
  parameter int unsigned SLEEP_UNIT = 1024
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  ewc_link_if.dev           link,
  input  wire logic         dem_bit_i,
  input  wire logic         cfg_we_i,
  input  wire logic [5:0]   cfg_lim_min_i,
  input  wire logic [5:0]   cfg_lim_max_i,
  input  wire logic [1:0]   cfg_band_i,
  input  wire logic [1:0]   cfg_nbit_i,
  input  wire logic [4:0]   cfg_sleep_i,
  output ewc_pkg::ewc_state_t state_o,
  output logic              receiving_o
);
  import ewc_pkg::*;

  ewc_state_t  state_q;
  logic [5:0]  lim_min_q;
  logic [5:0]  lim_max_q;
  logic [1:0]  band_q;
  logic [1:0]  nbit_q;
  logic [4:0]  sleep_q;
  logic [1:0]  dem_sq;
  logic [1:0]  line_sq;
  logic [1:0]  en_sq;
  logic        dem_s;
  logic        line_s;
  logic        en_s;
  logic [7:0]  base_cnt_q;
  logic [3:0]  x_cnt_q;
  logic        base_tick;
  logic        x_tick;
  logic [15:0] tcnt_q;
  logic [15:0] sleep_len;
  logic [5:0]  ivl_q;
  logic [4:0]  checks_q;
  logic        prev_q;
  logic [7:0]  offcnt_q;
  logic        out_q;
  logic [7:0]  ocnt_q;
  logic [7:0]  hold_min_q;
  logic        lock_q;
  logic [7:0]  ocnt_nx;

  // Interval inside the check window
  function automatic logic in_window(input logic [7:0] n, input logic [5:0] lo, input logic [5:0] hi);
    in_window = (n >= {2'h0, lo}) && (n < {2'h0, hi});
  endfunction

  // Configuration; the serial programming path is outside this core
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      lim_min_q <= LIM_MIN_RST;
      lim_max_q <= LIM_MAX_RST;
      band_q    <= BAND_RST;
      nbit_q    <= NBIT_RST;
      sleep_q   <= SLEEP_RST;
    end
    else if (cfg_we_i)
    begin
      lim_min_q <= cfg_lim_min_i;
      lim_max_q <= cfg_lim_max_i; // six bits cover 63
      band_q    <= cfg_band_i;
      nbit_q    <= cfg_nbit_i;
      sleep_q   <= cfg_sleep_i;
    end
  end

  // Two-stage synchronisers for pins
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      dem_sq  <= 2'h0;
      line_sq <= 2'h3;
      en_sq   <= 2'h3;
    end
    else
    begin
      dem_sq  <= {dem_sq[0], dem_bit_i};
      line_sq <= {line_sq[0], link.data_line};
      en_sq   <= {en_sq[0], link.enable};
    end
  end

  assign dem_s  = dem_sq[1];
  assign line_s = line_sq[1];
  assign en_s   = en_sq[1];

  // Base tick and band-scaled tick
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      base_cnt_q <= 8'h00;
      x_cnt_q    <= 4'h0;
    end
    else
    begin
      base_cnt_q <= base_tick ? 8'h00 : base_cnt_q + 8'h01;
      if (base_tick)
        x_cnt_q <= x_tick ? 4'h0 : x_cnt_q + 4'h1;
    end
  end

  assign base_tick = (base_cnt_q == 8'(BASE_TICK_CYC - 1));
  assign x_tick    = base_tick && (x_cnt_q >= ewc_band_div(band_q) - 4'h1);
  assign sleep_len = 16'(sleep_q * SLEEP_UNIT);

  // Polling, check and receive sequencing
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      state_q  <= ST_SLEEP;
      tcnt_q   <= 16'h0000;
      ivl_q    <= 6'h00;
      checks_q <= 5'h00;
      prev_q   <= 1'b0;
      offcnt_q <= 8'h00;
    end
    else if (!en_s)
    begin
      // Low enable parks in sleep; count restarts at the rise
      state_q <= ST_SLEEP;
      tcnt_q  <= 16'h0000;
    end
    else
    begin
      case (state_q)
        ST_SLEEP:
          if (tcnt_q >= sleep_len)
          begin
            state_q <= ST_START;
            tcnt_q  <= 16'h0000;
          end
          else if (base_tick)
            tcnt_q <= tcnt_q + 16'h0001;
        ST_START:
          // Demodulator output is meaningless here
          if (x_tick)
          begin
            if (tcnt_q[7:0] >= STARTUP_TICKS - 8'h01)
            begin
              state_q  <= (ewc_checks(nbit_q) == 5'h00) ? ST_RECV : ST_CHECK;
              ivl_q    <= 6'h00;
              checks_q <= 5'h00;
              offcnt_q <= 8'h00;
              prev_q   <= dem_s;
              tcnt_q   <= 16'h0000;
            end
            else
              tcnt_q <= tcnt_q + 16'h0001;
          end
        ST_CHECK:
          if (x_tick)
          begin
            prev_q <= dem_s; // one count per scaled tick
            if (dem_s != prev_q)
            begin
              if (ivl_q < lim_min_q)
                state_q <= ST_SLEEP;
              else
              begin
                ivl_q    <= 6'h00;
                checks_q <= checks_q + 5'h01;
                if (checks_q + 5'h01 >= ewc_checks(nbit_q))
                  state_q <= ST_RECV;
              end
            end
            else if (ivl_q + 6'h01 >= lim_max_q)
              state_q <= ST_SLEEP;
            else
              ivl_q <= ivl_q + 6'h01;
          end
        ST_RECV:
          // Besides a low enable, only a long host low while we release the line ends receiving
          if (x_tick)
          begin
            if (!line_s && out_q)
              offcnt_q <= (offcnt_q == 8'hff) ? offcnt_q : offcnt_q + 8'h01;
            else if (line_s && offcnt_q >= OFF_LOW_TICKS)
            begin
              state_q  <= ST_SYNC;
              tcnt_q   <= 16'h0000;
              offcnt_q <= 8'h00;
            end
            else
              offcnt_q <= 8'h00;
          end
        ST_SYNC:
          if (x_tick)
          begin
            if (tcnt_q[7:0] >= SYNC_TICKS - 8'h01)
            begin
              state_q <= ST_BIT; // single sync pulse
              tcnt_q  <= 16'h0000;
            end
            else
              tcnt_q <= tcnt_q + 16'h0001;
          end
        ST_BIT:
          if (x_tick)
          begin
            if (tcnt_q[7:0] >= BIT_TICKS - 8'h01)
            begin
              // First bit one is the off command; zero would be programming
              state_q <= line_s ? ST_SLEEP : ST_RECV;
              tcnt_q  <= 16'h0000;
            end
            else
              tcnt_q <= tcnt_q + 16'h0001;
          end
        default:
          state_q <= ST_SLEEP;
      endcase
    end
  end

  assign ocnt_nx = (ocnt_q == 8'hff) ? ocnt_q : ocnt_q + 8'h01;

  // Debounced, low-limited copy of the demodulated bit
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i || state_q != ST_RECV)
    begin
      out_q      <= 1'b1;
      ocnt_q     <= 8'h00;
      hold_min_q <= 8'h00;
      lock_q     <= 1'b0;
    end
    else if (x_tick)
    begin
      if (dem_s)
        lock_q <= 1'b0;
      if (!out_q && ocnt_nx >= LOW_MAX_TICKS)
      begin
        // Released low stays released until the bit goes high again
        out_q      <= 1'b1;
        lock_q     <= 1'b1;
        ocnt_q     <= 8'h00;
        hold_min_q <= HOLD_OUT_TICKS;
      end
      else if (dem_s != out_q && !(lock_q && !dem_s) && ocnt_nx >= hold_min_q)
      begin
        out_q      <= dem_s;
        hold_min_q <= in_window(ocnt_nx, lim_min_q, lim_max_q) ? HOLD_IN_TICKS : HOLD_OUT_TICKS;
        ocnt_q     <= 8'h00;
      end
      else
        ocnt_q <= ocnt_nx;
    end
  end

  // Open-drain drive: pulled low only in sync, or in receive while the copy is low
  assign link.data_dev_oen = (state_q == ST_RECV) ? out_q : (state_q != ST_SYNC);
  assign state_o           = state_q;
  assign receiving_o       = (state_q == ST_RECV);
endmodule // ewc_dev

// ---- ewc_host.sv ----
// Host end: AXI4-Lite registers ordering off or doze commands on the link.
// Assumes the receiver core sits on the other modport of the link.
`timescale 1ns/1ps
module ewc_host (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  ewc_link_if.host         link,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [3:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic [1:0]       s_axi_bresp_o,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [3:0]  s_axi_araddr_i,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o
);
  import ewc_pkg::*;

  ewc_hstate_t hs_q;
  logic        aw_q;
  logic        w_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [15:0] off_low_q;
  logic [15:0] doze_q;
  logic [15:0] cnt_q;
  logic        sync_seen_q;
  logic        low_seen_q;
  logic [1:0]  line_sq;
  logic        line_s;
  logic        wr_go;
  logic        start_off;
  logic        start_doze;

  // Line level passes two flops before use
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      line_sq <= 2'h3;
    else
      line_sq <= {line_sq[0], link.data_line};
  end

  assign line_s = line_sq[1];

  // Write address and data taken in either order
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q  <= 32'h0000_0000;
    end
    else if (wr_go)
    begin
      aw_q <= 1'b0;
      w_q  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata_i;
      end
    end
  end

  assign s_axi_awready_o = !aw_q && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_q && !s_axi_bvalid_o;
  assign wr_go           = aw_q && w_q;
  assign start_off       = wr_go && awaddr_q == REG_CTRL && wdata_q[0] && hs_q == HS_IDLE;
  assign start_doze      = wr_go && awaddr_q == REG_CTRL && wdata_q[1] && !wdata_q[0] && hs_q == HS_IDLE;

  // Register writes and write response
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      off_low_q      <= OFF_LOW_RST;
      doze_q         <= DOZE_RST;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= RESP_OKAY;
      if (awaddr_q == REG_OFF_LOW && s_axi_wstrb_i != 4'h0)
        off_low_q <= wdata_q[15:0]; // software sets the low time
      else if (awaddr_q == REG_DOZE)
        doze_q <= wdata_q[15:0];
      else if (awaddr_q != REG_CTRL)
        s_axi_bresp_o <= RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
  end

  // Register reads
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= RESP_OKAY;
      if (s_axi_araddr_i == REG_OFF_LOW)
        s_axi_rdata_o <= {16'h0000, off_low_q};
      else if (s_axi_araddr_i == REG_DOZE)
        s_axi_rdata_o <= {16'h0000, doze_q};
      else if (s_axi_araddr_i == REG_STATUS)
        s_axi_rdata_o <= {28'h000_0000, hs_q, sync_seen_q, line_s};
      else if (s_axi_araddr_i == REG_CTRL)
        s_axi_rdata_o <= 32'h0000_0000;
      else
      begin
        s_axi_rdata_o <= 32'h0000_0000;
        s_axi_rresp_o <= RESP_SLVERR;
      end
    end
    else if (s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  assign s_axi_arready_o = !s_axi_rvalid_o;

  // Link command sequencer
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      hs_q        <= HS_IDLE;
      cnt_q       <= 16'h0000;
      sync_seen_q <= 1'b0;
      low_seen_q  <= 1'b0;
    end
    else
    begin
      case (hs_q)
        HS_IDLE:
          if (start_off)
          begin
            hs_q        <= HS_OFF;
            cnt_q       <= 16'h0000;
            sync_seen_q <= 1'b0;
          end
          else if (start_doze)
          begin
            hs_q  <= HS_DOZE;
            cnt_q <= 16'h0000;
          end
        HS_OFF:
          if (cnt_q + 16'h0001 >= off_low_q)
          begin
            hs_q       <= HS_SYNC;
            low_seen_q <= 1'b0;
          end
          else
            cnt_q <= cnt_q + 16'h0001;
        HS_SYNC:
          // Leaving the line high answers the sync with a one
          if (!line_s)
            low_seen_q <= 1'b1;
          else if (low_seen_q)
          begin
            sync_seen_q <= 1'b1;
            hs_q        <= HS_IDLE;
          end
        HS_DOZE:
          if (cnt_q + 16'h0001 >= doze_q)
            hs_q <= HS_IDLE;
          else
            cnt_q <= cnt_q + 16'h0001;
        default:
          hs_q <= HS_IDLE;
      endcase
    end
  end

  assign link.data_host_oen = (hs_q != HS_OFF);
  assign link.enable        = (hs_q != HS_DOZE);
endmodule // ewc_host

// ---- ewc_link_props.sv ----
// Checker on the link signals between the receiver core and the host end.
// Assumes the core runs band 3 (TICK_CYC clocks per scaled tick) whenever it drives data.
`timescale 1ns/1ps
module ewc_link_props #(
  parameter int TICK_CYC    = 20,
  parameter int OFF_LOW_CYC = 2100,
  parameter int DOZE_CYC    = 600
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic data_dev_oen,
  input wire logic data_host_oen,
  input wire logic data_line,
  input wire logic enable
);
  localparam int SYNC_WAIT = 30;
  localparam int HOLD_CYC  = 8 * TICK_CYC;
  localparam int SYNC_CYC  = 8 * TICK_CYC;
  localparam int LOW_CYC   = 80 * TICK_CYC;
  logic dprev_q;
  logic arm_q;
  int   drun_q;
  int   hlow_q;
  int   elow_q;

  // Length of the device level so far; equals the old run at a change
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      dprev_q <= 1'b1;
      drun_q  <= 0;
    end
    else
    begin
      dprev_q <= data_dev_oen;
      drun_q  <= (data_dev_oen != dprev_q) ? 1 : drun_q + 1;
    end
  end

  // Low runs of host drive and enable, read at the release sample
  always_ff @(posedge clk_sys_i)
  begin
    hlow_q <= (!rstn_i || data_host_oen) ? 0 : hlow_q + 1;
    elow_q <= (!rstn_i || enable) ? 0 : elow_q + 1;
  end

  // Armed from host release to end of sync; doze drops it, no stale pulse
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i || !enable)
      arm_q <= 1'b0;
    else if (data_host_oen && hlow_q != 0)
      arm_q <= 1'b1;
    else if (data_dev_oen && !dprev_q)
      arm_q <= 1'b0;
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  sequence seq_off_done;
    $rose(data_host_oen) && enable;
  endsequence
  sequence seq_sync_end;
    data_dev_oen && !dprev_q && arm_q;
  endsequence

  a_reset_idle: assert property ($rose(rstn_i) |-> data_dev_oen && data_host_oen && enable && data_line)
    else $error("link not idle after reset");
  a_edge_hold: assert property ((data_dev_oen != dprev_q) && enable |-> drun_q >= HOLD_CYC)
    else $error("device level held too briefly");
  a_low_limit: assert property (!data_dev_oen && !dprev_q |-> drun_q < LOW_CYC)
    else $error("device low run too long");
  a_off_low_len: assert property (data_host_oen && hlow_q != 0 |-> hlow_q >= OFF_LOW_CYC && hlow_q <= OFF_LOW_CYC + 1)
    else $error("host off low time wrong");
  a_sync_start: assert property (seq_off_done |-> ##[1:SYNC_WAIT] !data_dev_oen)
    else $error("no sync pulse after off command");
  a_sync_len: assert property (seq_sync_end |-> drun_q == SYNC_CYC)
    else $error("sync pulse length wrong");
  a_single_sync: assert property (seq_sync_end |=> data_dev_oen [*8])
    else $error("second pulse after sync");
  a_doze_len: assert property (enable && elow_q != 0 |-> elow_q >= DOZE_CYC && elow_q <= DOZE_CYC + 1)
    else $error("doze pulse length wrong");
  a_sleep_quiet: assert property (!enable && elow_q >= 4 |-> data_dev_oen)
    else $error("device drives data while enable low");
endmodule // ewc_link_props

// ---- edge_window_check_and_data_output_test.sv ----
// Bench joining the receiver core and the host end on one link.
// Assumes SLEEP_UNIT 2; band 3 limits 10/16 are loaded after the default run.
`timescale 1ns/1ps
module edge_window_check_and_data_output_test;
  import ewc_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        dem       = 1'b1;
  logic        cfg_we    = 1'b0;
  logic [5:0]  lmin      = 6'h0a; // lower count kept at ten or more
  logic [5:0]  lmax      = 6'h10; // upper count well under the ceiling
  logic [1:0]  band      = 2'h3;
  logic [1:0]  nbit      = 2'h1;
  logic [4:0]  slp       = 5'h01;
  logic        aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
  logic [3:0]  aw_a = 4'h0, ar_a = 4'h0;
  logic [31:0] w_d  = 32'h0000_0000;
  logic        aw_r, w_r, b_v, ar_r, r_v, recv;
  logic [1:0]  b_resp, r_resp;
  logic [31:0] r_d, rd;
  ewc_state_t  st;
  int          n_fail   = 0;
  int          compares = 0;
  int          n;

  always #50 clk_sys_i = ~clk_sys_i;

  ewc_link_if link ();
  ewc_dev #(.SLEEP_UNIT(2)) i_ewc_dev (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(link), .dem_bit_i(dem),
    .cfg_we_i(cfg_we), .cfg_lim_min_i(lmin), .cfg_lim_max_i(lmax), .cfg_band_i(band), .cfg_nbit_i(nbit),
    .cfg_sleep_i(slp), .state_o(st), .receiving_o(recv));
  ewc_host i_ewc_host (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(link),
    .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_r), .s_axi_awaddr_i(aw_a), .s_axi_wvalid_i(w_v),
    .s_axi_wready_o(w_r), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(b_v),
    .s_axi_bready_i(b_rdy), .s_axi_bresp_o(b_resp), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_r),
    .s_axi_araddr_i(ar_a), .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_rdy), .s_axi_rdata_o(r_d),
    .s_axi_rresp_o(r_resp));
  ewc_link_props #(.TICK_CYC(20), .OFF_LOW_CYC(2100), .DOZE_CYC(600)) u_props (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .data_dev_oen(link.data_dev_oen), .data_host_oen(link.data_host_oen),
    .data_line(link.data_line), .enable(link.enable));

  task automatic close_out();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // A wait that runs out ends the run at once
  task automatic hang();
    n_fail++;
    $display("[ERR] t=%0t wait expired", $time);
    close_out();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input int v, input int lo, input int hi);
    compares++;
    if (v < lo || v > hi)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask

  task automatic wait_st(input ewc_state_t s, input int lim, output int c);
    c = 0;
    while (st !== s)
    begin
      @(posedge clk_sys_i);
      c++;
      if (c > lim)
        hang();
    end
  endtask

  task automatic wait_ln(input logic lvl, input int lim, output int c);
    c = 0;
    while (link.data_line !== lvl)
    begin
      @(posedge clk_sys_i);
      c++;
      if (c > lim)
        hang();
    end
  endtask

  // Address and data offered together; bready held until the answer
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int c;
    c = 0;
    aw_a  <= a;
    w_d   <= d;
    aw_v  <= 1'b1;
    w_v   <= 1'b1;
    b_rdy <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (aw_v && aw_r)
        aw_v <= 1'b0;
      if (w_v && w_r)
        w_v <= 1'b0;
      c++;
      if (c > 20)
        hang();
    end
    while (!(b_v && b_rdy));
    b_rdy <= 1'b0;
    chk({30'h0, b_resp}, {30'h0, er});
    @(posedge clk_sys_i);
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
    int c;
    c = 0;
    ar_a  <= a;
    ar_v  <= 1'b1;
    r_rdy <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (ar_v && ar_r)
        ar_v <= 1'b0;
      c++;
      if (c > 20)
        hang();
    end
    while (!(r_v && r_rdy));
    d = r_d;
    r_rdy <= 1'b0;
    chk({30'h0, r_resp}, {30'h0, er});
    @(posedge clk_sys_i);
  endtask

  task automatic load(input logic [1:0] code);
    nbit   <= code;
    cfg_we <= 1'b1;
    @(posedge clk_sys_i);
    cfg_we <= 1'b0;
  endtask

  task automatic t_reset();
    chk({26'h0, st, recv, link.data_line, link.enable}, {26'h0, ST_SLEEP, 3'b011});
    axi_rd(REG_OFF_LOW, RESP_OKAY, rd);
    chk(rd, {16'h0, OFF_LOW_RST});
    axi_rd(REG_DOZE, RESP_OKAY, rd);
    chk(rd, {16'h0, DOZE_RST});
    axi_rd(REG_CTRL, RESP_OKAY, rd);
    chk(rd, 32'h0000_0000);
    axi_wr(4'h2, 32'h0000_0000, RESP_SLVERR);
    axi_wr(REG_DOZE, 32'h0000_0258, RESP_OKAY);
    axi_wr(REG_OFF_LOW, 32'h0000_0834, RESP_OKAY);
    axi_rd(REG_OFF_LOW, RESP_OKAY, rd);
    chk(rd, 32'h0000_0834);
  endtask

  // Default limits at band 0: no edge, so the upper count ends the check
  task automatic t_default();
    wait_st(ST_CHECK, 8000, n);
    wait_st(ST_SLEEP, 5000, n);
    chk_in(n, 22 * 160, 25 * 160);
  endtask

  // Doze, then exactly the selected number of in-window edges
  task automatic t_nbit(input logic [1:0] code);
    int k;
    load(code);
    axi_wr(REG_CTRL, 32'h0000_0002, RESP_OKAY);
    cyc(300);
    chk({30'h0, st === ST_SLEEP, link.enable}, 32'h0000_0002);
    wait_st(code == 2'h0 ? ST_RECV : ST_CHECK, 3000, n);
    for (k = 0; k < 6 * code; k++)
    begin
      cyc(260);
      chk({31'h0, recv}, 32'h0000_0000);
      dem <= ~dem;
    end
    cyc(60);
    chk({28'h0, st, recv}, {28'h0, ST_RECV, 1'b1});
  endtask

  // Spike stretched to the out-of-window hold, then a stuck low cut off
  task automatic t_shape();
    dem <= 1'b0;
    wait_ln(1'b0, 60, n);
    // Bit back high at once; the low must still stand the full hold
    dem <= 1'b1;
    wait_ln(1'b1, 400, n);
    chk_in(n, 200, 200);
    cyc(400);
    dem <= 1'b0;
    wait_ln(1'b0, 60, n);
    wait_ln(1'b1, 2000, n);
    chk_in(n, 1600, 1600);
    chk({31'h0, recv}, 32'h0000_0001);
    dem <= 1'b1;
    cyc(400);
  endtask

  // Off over data, then short edge, ignored settle toggle and no edge
  // Bands 1 and 2 then show the tick scaling through the upper limit
  task automatic t_off();
    int k;
    load(2'h1);
    axi_wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    wait_st(ST_SLEEP, 4000, n);
    chk_in(n, 2560, 2680);
    axi_rd(REG_STATUS, RESP_OKAY, rd);
    chk(rd & 32'h0000_000f, 32'h0000_0003);
    wait_st(ST_CHECK, 2000, n);
    cyc(100);
    dem <= ~dem;
    wait_st(ST_SLEEP, 80, n);
    wait_st(ST_START, 200, n);
    cyc(600);
    dem <= ~dem;
    wait_st(ST_CHECK, 100, n);
    wait_st(ST_SLEEP, 500, n);
    chk_in(n, 280, 340);
    for (k = 1; k < 3; k++)
    begin
      band <= 2'(k);
      load(2'h1);
      wait_st(ST_CHECK, 3000, n);
      wait_st(ST_SLEEP, 2000, n);
      chk_in(n, 16 * 20 * (8 >> k), 16 * 20 * (8 >> k));
    end
  endtask

  initial
  begin
    cyc(3);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_default();
    t_nbit(2'h1);
    t_nbit(2'h2);
    t_nbit(2'h3);
    t_nbit(2'h0);
    t_shape();
    t_off();
    close_out();
  end
endmodule // edge_window_check_and_data_output_test
